//--- tco_pkg.sv
// constants shared by the sensor model and the host readout
// assumes a single 100 MHz system clock on both ends
package tco_pkg;
   localparam int unsigned CLK_HZ        = 100_000_000;
   localparam int unsigned TEMP_W        = 16;
   localparam int unsigned COUNT_W       = 32;
   // period variant scale factors, microseconds per kelvin
   localparam int unsigned PER_SCALE_00  = 10;
   localparam int unsigned PER_SCALE_01  = 40;
   localparam int unsigned PER_SCALE_10  = 160;
   localparam int unsigned PER_SCALE_11  = 640;
   // frequency variant scale factors, sixteenths of a hertz per kelvin
   localparam int unsigned FRQ_SCALE_00  = 64;
   localparam int unsigned FRQ_SCALE_01  = 16;
   localparam int unsigned FRQ_SCALE_10  = 4;
   localparam int unsigned FRQ_SCALE_11  = 1;
   localparam int unsigned FRQ_DEN       = 16;
   localparam int unsigned US_HZ         = 1_000_000;
   // host gate: twenty ticks of 50 ms
   localparam int unsigned TICK_MS       = 50;
   localparam int unsigned TICKS_PER_GATE = 20;
   localparam int unsigned TICK_CYC      = CLK_HZ / 1000 * TICK_MS;
   // 8-bit style gate timer reload bytes
   localparam logic [7:0]  GATE_RELOAD_HI = 8'h3C;
   localparam logic [7:0]  GATE_RELOAD_LO = 8'hB0;
   // kelvin offset in hundredths
   localparam int unsigned KELVIN_X100   = 27315;

   typedef enum logic [1:0]
   {
      VARIANT_PERIOD = 2'h0,
      VARIANT_FREQ   = 2'h1
   } variant_t;

   // half period in clock cycles for a temperature in kelvin
   function automatic logic [COUNT_W-1:0] half_period_cyc
      (input logic is_freq, input logic [1:0] sel,
       input logic [TEMP_W-1:0] kelvin);
      logic [63:0] s;
      logic [63:0] r;
      s = 64'h0;
      r = 64'h0;
      if (!is_freq)
      begin
         unique case (sel)
            2'b00: s = 64'(PER_SCALE_00);
            2'b01: s = 64'(PER_SCALE_01);
            2'b10: s = 64'(PER_SCALE_10);
            2'b11: s = 64'(PER_SCALE_11);
         endcase
         r = s * 64'(kelvin) * 64'(CLK_HZ / US_HZ) / 64'h2;
      end
      else
      begin
         unique case (sel)
            2'b00: s = 64'(FRQ_SCALE_00);
            2'b01: s = 64'(FRQ_SCALE_01);
            2'b10: s = 64'(FRQ_SCALE_10);
            2'b11: s = 64'(FRQ_SCALE_11);
         endcase
         s = s * 64'(kelvin);
         if (s == 64'h0)
            s = 64'h1;
         r = 64'(CLK_HZ) * 64'(FRQ_DEN) / (s * 64'h2);
      end
      if (r == 64'h0)
         r = 64'h1;
      half_period_cyc = r[COUNT_W-1:0];
   endfunction : half_period_cyc
endpackage : tco_pkg

//--- tco_link_if.sv
// single-wire link from sensor output to host input
// plus the two hard-wired time-select straps seen by both ends
`timescale 1ns/1ps
interface tco_link_if;
   logic sensor_out;
   logic time_select_high_pin;
   logic time_select_low_pin;
   modport sensor
   (
      output sensor_out,
      input  time_select_high_pin,
      input  time_select_low_pin
   );
   modport host
   (
      input sensor_out,
      input time_select_high_pin,
      input time_select_low_pin
   );
endinterface : tco_link_if

//--- tco_host.sv
// host readout: measures the sensor wave, converts to centi-celsius
// assumes sensor output is asynchronous; straps are static
// Overview of operation
// R1 - period scale 10/40/160/640 us per kelvin
// R2 - frequency scale 4/1/0.25/0.0625 Hz per kelvin
// R3 - period variant: 50% wave, period scale*T
// R4 - frequency variant: 50% wave, freq scale*T
// R5 - period celsius: period/scale minus 273.15
// R6 - frequency celsius: freq/scale minus 273.15
// R7 - count edges over twenty 50 ms ticks
// R8 - read high, low; reread on high change; code captures both bytes in one cycle
// R9 - clear counter, set new-temperature flag
// R10 - reload tick timer 03C/0B0 minus latency; code reloads 3C/B0 exact
// R11 - period variant measures period duration
// R12 - longer scales average noise better
// R13 - two-flop synchronise sensor before edge use
`timescale 1ns/1ps
module tco_host #(
   parameter tco_pkg::variant_t VARIANT  = tco_pkg::VARIANT_FREQ,
   parameter int unsigned       TICK_CYC = tco_pkg::TICK_CYC
) (
   // clock and reset
   input  wire logic                          sys_clk_i,
   input  wire logic                          rst_b_i,
   // link
   tco_link_if.host                           link,
   // user side
   input  wire logic                          flag_clear_i,
   output logic                               new_temperature_flag_o,
   output logic [tco_pkg::COUNT_W-1:0]        raw_count_o,
   output logic signed [31:0]                 temp_centi_c_o
);
   logic                          sync_a;
   logic                          sync_b;
   logic                          sync_d;
   logic                          rise;
   logic [7:0]                    edge_counter_high_byte;
   logic [7:0]                    edge_counter_low_byte;
   logic [7:0]                    captured_count_high;
   logic [7:0]                    captured_count_low;
   logic [7:0]                    gate_timer_high_byte;
   logic [7:0]                    gate_timer_low_byte;
   logic [31:0]                   tick_cnt;
   logic                          tick;
   logic [4:0]                    ticks_left;
   logic                          gate_end;
   logic [tco_pkg::COUNT_W-1:0]   period_cnt;
   logic [1:0]                    sel;
   logic [31:0]                   next_scale;

   assign sel = {link.time_select_high_pin, link.time_select_low_pin};

   // first flop feeds only the second
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
      if (!rst_b_i)
      begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         sync_d <= 1'b0;
      end
      else
      begin
         sync_a <= link.sensor_out; // R13
         sync_b <= sync_a; // R13
         sync_d <= sync_b;
      end

   assign rise = sync_b & ~sync_d;

   // 50 ms tick; byte view of the reload kept for software parity.
   // hardware has no service latency, so the low byte reloads exact.
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
      if (!rst_b_i)
      begin
         tick_cnt             <= 32'h0000_0000;
         gate_timer_high_byte <= tco_pkg::GATE_RELOAD_HI;
         gate_timer_low_byte  <= tco_pkg::GATE_RELOAD_LO;
      end
      else if (tick_cnt == TICK_CYC - 1)
      begin
         tick_cnt             <= 32'h0000_0000;
         gate_timer_high_byte <= tco_pkg::GATE_RELOAD_HI; // R10
         gate_timer_low_byte  <= tco_pkg::GATE_RELOAD_LO; // R10
      end
      else
         tick_cnt <= tick_cnt + 32'h0000_0001;

   assign tick = (tick_cnt == TICK_CYC - 1);

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
      if (!rst_b_i)
         ticks_left <= 5'(tco_pkg::TICKS_PER_GATE);
      else if (tick)
         ticks_left <= (ticks_left == 5'h01) ?
                       5'(tco_pkg::TICKS_PER_GATE) : ticks_left - 5'h01; // R7

   assign gate_end = (VARIANT == tco_pkg::VARIANT_FREQ)
                     ? (tick && ticks_left == 5'h01)
                     : rise; // R11

   // edge or period counter as two bytes; both read in one cycle so
   // the high/low tear of a software read cannot occur
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
      if (!rst_b_i)
      begin
         edge_counter_high_byte <= 8'h00;
         edge_counter_low_byte  <= 8'h00;
      end
      else if (gate_end)
      begin
         edge_counter_high_byte <= 8'h00; // R9
         edge_counter_low_byte  <= 8'h00; // R9
      end
      else if (VARIANT == tco_pkg::VARIANT_FREQ ? rise : 1'b1) // R7
         {edge_counter_high_byte, edge_counter_low_byte} <=
            {edge_counter_high_byte, edge_counter_low_byte} + 16'h0001;

   // period variant counts full clocks between rising edges
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
      if (!rst_b_i)
         period_cnt <= '0;
      else if (rise)
         period_cnt <= {{(tco_pkg::COUNT_W-1){1'b0}}, 1'b1}; // R11
      else
         period_cnt <= period_cnt + 1'b1;

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
      if (!rst_b_i)
      begin
         captured_count_high <= 8'h00;
         captured_count_low  <= 8'h00;
         raw_count_o         <= '0;
      end
      else if (gate_end)
      begin
         captured_count_high <= edge_counter_high_byte; // R8
         captured_count_low  <= edge_counter_low_byte; // R8
         raw_count_o         <= (VARIANT == tco_pkg::VARIANT_FREQ)
            ? {16'h0000, edge_counter_high_byte, edge_counter_low_byte}
            : period_cnt;
      end

   // set wins over a simultaneous clear
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
      if (!rst_b_i)
         new_temperature_flag_o <= 1'b0;
      else if (gate_end)
         new_temperature_flag_o <= 1'b1; // R9
      else if (flag_clear_i)
         new_temperature_flag_o <= 1'b0;

   // conversion: centi-celsius, integer division
   // in the period variant longer scales give longer counts and so average more noise
   // R12
   always_comb
   begin
      next_scale = 32'h0000_0001;
      if (VARIANT == tco_pkg::VARIANT_PERIOD)
         unique case (sel)
            2'b00: next_scale = 32'(tco_pkg::PER_SCALE_00);
            2'b01: next_scale = 32'(tco_pkg::PER_SCALE_01);
            2'b10: next_scale = 32'(tco_pkg::PER_SCALE_10);
            2'b11: next_scale = 32'(tco_pkg::PER_SCALE_11);
         endcase
      else
         unique case (sel)
            2'b00: next_scale = 32'(tco_pkg::FRQ_SCALE_00);
            2'b01: next_scale = 32'(tco_pkg::FRQ_SCALE_01);
            2'b10: next_scale = 32'(tco_pkg::FRQ_SCALE_10);
            2'b11: next_scale = 32'(tco_pkg::FRQ_SCALE_11);
         endcase
   end

   // gate is one second, so the captured count is hertz
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
      if (!rst_b_i)
         temp_centi_c_o <= 32'sh0000_0000;
      else if (new_temperature_flag_o == 1'b0 && gate_end)
      begin
         if (VARIANT == tco_pkg::VARIANT_PERIOD)
            temp_centi_c_o <= 32'(signed'(
               64'(period_cnt) * 64'd100
               / (64'(next_scale) * 64'(tco_pkg::CLK_HZ / tco_pkg::US_HZ))
               - 64'(tco_pkg::KELVIN_X100))); // R5
         else
            temp_centi_c_o <= 32'(signed'(
               64'({edge_counter_high_byte, edge_counter_low_byte})
               * 64'd100 * 64'(tco_pkg::FRQ_DEN) / 64'(next_scale)
               - 64'(tco_pkg::KELVIN_X100))); // R6
      end
      else if (gate_end)
      begin
         if (VARIANT == tco_pkg::VARIANT_PERIOD)
            temp_centi_c_o <= 32'(signed'(
               64'(period_cnt) * 64'd100
               / (64'(next_scale) * 64'(tco_pkg::CLK_HZ / tco_pkg::US_HZ))
               - 64'(tco_pkg::KELVIN_X100))); // R5
         else
            temp_centi_c_o <= 32'(signed'(
               64'({edge_counter_high_byte, edge_counter_low_byte})
               * 64'd100 * 64'(tco_pkg::FRQ_DEN) / 64'(next_scale)
               - 64'(tco_pkg::KELVIN_X100))); // R6
      end
endmodule : tco_host

//--- tco_sensor.sv
// sensor end: temperature-controlled oscillator model in logic
// assumes die temperature in kelvin arrives as a static user input
`timescale 1ns/1ps
module tco_sensor #(
   parameter tco_pkg::variant_t VARIANT = tco_pkg::VARIANT_FREQ
) (
   // clock and reset
   input  wire logic                          sys_clk_i,
   input  wire logic                          rst_b_i,
   // link
   tco_link_if.sensor                         link,
   // user side
   input  wire logic [tco_pkg::TEMP_W-1:0]    kelvin_i
);
   logic [tco_pkg::COUNT_W-1:0] half_cnt;
   logic [tco_pkg::COUNT_W-1:0] half_len;
   logic                        temp_controlled_oscillator;

   // straps read every clock so a change sets the timing of the next edge
   assign half_len = tco_pkg::half_period_cyc(
      VARIANT == tco_pkg::VARIANT_FREQ,
      {link.time_select_high_pin, link.time_select_low_pin},
      kelvin_i); // R1 R2

   // equal halves give 50% duty
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
      if (!rst_b_i)
      begin
         half_cnt                   <= '0;
         temp_controlled_oscillator <= 1'b0;
      end
      else if (half_cnt >= half_len - 1'b1)
      begin
         half_cnt                   <= '0;
         temp_controlled_oscillator <= ~temp_controlled_oscillator; // R3 R4
      end
      else
         half_cnt <= half_cnt + 1'b1;

   assign link.sensor_out = temp_controlled_oscillator;
endmodule : tco_sensor

//--- tco_link_asserts.sv
// checker for the period-variant link and its host flag
// assumes the watched pair runs the period variant
`timescale 1ns/1ps
module tco_link_asserts
(
   // clock and reset
   input wire logic                         sys_clk_i,
   input wire logic                         rst_b_i,
   // link
   input wire logic                         sensor_out,
   input wire logic                         time_select_high_pin,
   input wire logic                         time_select_low_pin,
   input wire logic [tco_pkg::TEMP_W-1:0]   kelvin_i,
   // host user side
   input wire logic                         flag_clear_i,
   input wire logic                         new_temperature_flag_o,
   input wire logic [tco_pkg::COUNT_W-1:0]  raw_count_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   int unsigned scale;
   logic [31:0] exp_half;
   logic [31:0] run_len;
   logic        run_seen;
   logic        last_out;
   logic [7:0]  since_rise;
   always_comb
   begin
      case ({time_select_high_pin, time_select_low_pin})
         2'b00:   scale = tco_pkg::PER_SCALE_00;
         2'b01:   scale = tco_pkg::PER_SCALE_01;
         2'b10:   scale = tco_pkg::PER_SCALE_10;
         default: scale = tco_pkg::PER_SCALE_11;
      endcase
      exp_half = 32'(scale * kelvin_i * 100 / 2);
   end
   // first run after reset is skipped: its start is not a toggle
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         run_len  <= 32'h0000_0001;
         run_seen <= 1'b0;
         last_out <= 1'b0;
      end
      else
      begin
         last_out <= sensor_out;
         run_len  <= (sensor_out != last_out) ? 32'h0000_0001
                                               : run_len + 32'h0000_0001;
         if (sensor_out != last_out)
            run_seen <= 1'b1;
      end
   end
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         since_rise <= 8'hFF;
      else if (sensor_out && !last_out)
         since_rise <= 8'h00;
      else if (since_rise != 8'hFF)
         since_rise <= since_rise + 8'h01;
   end
   a_start_low: assert property ($rose(rst_b_i) |-> (!sensor_out) [*8])
      else $error("wave not low after reset");
   a_half_width: assert property (sensor_out != last_out && run_seen |-> run_len == exp_half)
      else $error("half period wrong");
   a_run_bound: assert property (run_seen |-> run_len <= exp_half)
      else $error("wave held too long");
   a_flag_follows: assert property ($rose(sensor_out) |-> ##[2:5] new_temperature_flag_o)
      else $error("no result after rise");
   a_flag_sync: assert property ($rose(new_temperature_flag_o) |-> since_rise inside {[2:5]})
      else $error("flag timing off");
   a_flag_holds: assert property (new_temperature_flag_o && !flag_clear_i |=> new_temperature_flag_o)
      else $error("flag dropped");
   a_flag_clears: assert property (flag_clear_i && since_rise > 8'd6 |=> !new_temperature_flag_o)
      else $error("flag not cleared");
   a_raw_cause: assert property ($changed(raw_count_o) |-> since_rise <= 8'd5)
      else $error("count changed off a rise");
endmodule : tco_link_asserts

//--- testbench.sv
// testbench: period pair and frequency pair on shared straps
// assumes one 100 MHz clock for both ends
`timescale 1ns/1ps
module testbench;
   localparam int unsigned TICK = 300;
   logic                        sys_clk_i;
   logic                        rst_b_i;
   logic [1:0]                  sel;
   logic [tco_pkg::TEMP_W-1:0]  k_per;
   logic [tco_pkg::TEMP_W-1:0]  k_frq;
   logic                        clr_per;
   logic                        clr_frq;
   logic                        flag_per;
   logic                        flag_frq;
   logic [tco_pkg::COUNT_W-1:0] raw_per;
   logic [tco_pkg::COUNT_W-1:0] raw_frq;
   logic signed [31:0]          temp_per;
   logic signed [31:0]          temp_frq;
   int                          failures;
   int                          compares;
   tco_link_if per_link ();
   tco_link_if frq_link ();
   assign per_link.time_select_high_pin = sel[1];
   assign per_link.time_select_low_pin  = sel[0];
   assign frq_link.time_select_high_pin = sel[1];
   assign frq_link.time_select_low_pin  = sel[0];
   tco_sensor #(.VARIANT(tco_pkg::VARIANT_PERIOD)) tco_sensor_inst
      (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .link(per_link),
       .kelvin_i(k_per));
   tco_host #(.VARIANT(tco_pkg::VARIANT_PERIOD)) tco_host_inst
      (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .link(per_link),
       .flag_clear_i(clr_per), .new_temperature_flag_o(flag_per),
       .raw_count_o(raw_per), .temp_centi_c_o(temp_per));
   tco_sensor #(.VARIANT(tco_pkg::VARIANT_FREQ)) tco_sensor_freq_inst
      (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .link(frq_link),
       .kelvin_i(k_frq));
   tco_host #(.VARIANT(tco_pkg::VARIANT_FREQ), .TICK_CYC(TICK))
      tco_host_freq_inst
      (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .link(frq_link),
       .flag_clear_i(clr_frq), .new_temperature_flag_o(flag_frq),
       .raw_count_o(raw_frq), .temp_centi_c_o(temp_frq));
   tco_link_asserts tco_link_asserts_inst
      (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
       .sensor_out(per_link.sensor_out),
       .time_select_high_pin(per_link.time_select_high_pin),
       .time_select_low_pin(per_link.time_select_low_pin),
       .kelvin_i(k_per), .flag_clear_i(clr_per),
       .new_temperature_flag_o(flag_per), .raw_count_o(raw_per));
   initial
   begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   function automatic logic wire_of(input bit f);
      return f ? frq_link.sensor_out : per_link.sensor_out;
   endfunction : wire_of
   task automatic check(input bit ok, input string msg);
      compares++;
      if (!ok)
      begin
         failures++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask : check
   task automatic test_done;
      if (failures == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done
   // straps only move while reset is held
   task automatic restart(input logic [1:0] s);
      @(negedge sys_clk_i);
      rst_b_i = 1'b0;
      sel = s;
      repeat (2) @(negedge sys_clk_i);
      rst_b_i = 1'b1;
   endtask : restart
   task automatic high_width(input bit f, output int n);
      int guard;
      guard = 0;
      while (wire_of(f) !== 1'b1 && guard < 70000)
      begin
         @(negedge sys_clk_i);
         guard++;
      end
      n = 0;
      while (wire_of(f) === 1'b1 && n < 70000)
      begin
         @(negedge sys_clk_i);
         n++;
      end
   endtask : high_width
   task automatic wait_flag(input bit f, output int n);
      n = 0;
      while ((f ? flag_frq : flag_per) !== 1'b1 && n < 30000)
      begin
         @(negedge sys_clk_i);
         n++;
      end
   endtask : wait_flag
   task automatic pulse_clear(input bit f);
      @(negedge sys_clk_i);
      if (f) clr_frq = 1'b1; else clr_per = 1'b1;
      @(negedge sys_clk_i);
      clr_frq = 1'b0;
      clr_per = 1'b0;
   endtask : pulse_clear
   task automatic test_scales;
      int hp;
      int hf;
      int ps [4];
      int fs [4];
      ps = '{tco_pkg::PER_SCALE_00, tco_pkg::PER_SCALE_01,
             tco_pkg::PER_SCALE_10, tco_pkg::PER_SCALE_11};
      fs = '{tco_pkg::FRQ_SCALE_00, tco_pkg::FRQ_SCALE_01,
             tco_pkg::FRQ_SCALE_10, tco_pkg::FRQ_SCALE_11};
      for (int s = 0; s < 4; s++)
      begin
         restart(2'(s));
         fork
            high_width(1'b0, hp);
            high_width(1'b1, hf);
         join
         check(hp == ps[s] * 100 / 2, "period half width");
         check(hf == 1600000000 / (2 * fs[s] * 65535), "freq half width");
      end
   endtask : test_scales
   task automatic test_freq_gate;
      int n;
      restart(2'b00);
      wait_flag(1'b1, n);
      check(n >= 20 * TICK - 1 && n <= 20 * TICK + 1, "gate length");
      check(raw_frq >= 14 && raw_frq <= 17, "edge count");
      check(temp_frq === 32'(int'(raw_frq) * 100 * tco_pkg::FRQ_DEN
            / tco_pkg::FRQ_SCALE_00 - tco_pkg::KELVIN_X100), "freq celsius");
      pulse_clear(1'b1);
      check(flag_frq === 1'b0, "flag stuck");
      wait_flag(1'b1, n);
      check(n >= 20 * TICK - 3 && n <= 20 * TICK + 1, "gate reload");
      check(raw_frq >= 14 && raw_frq <= 17, "count not zeroed");
   endtask : test_freq_gate
   task automatic test_period_read;
      int n;
      int raw_exp;
      for (int c = 0; c < 2; c++)
      begin
         restart(c ? 2'b01 : 2'b00);
         wait_flag(1'b0, n);
         pulse_clear(1'b0);
         wait_flag(1'b0, n);
         raw_exp = (c ? tco_pkg::PER_SCALE_01 : tco_pkg::PER_SCALE_00) * 100;
         check(raw_per === 32'(raw_exp), "period count");
         check(temp_per === 32'(100 - 27315), "celsius");
      end
   endtask : test_period_read
   initial
   begin
      rst_b_i = 1'b0;
      sel = 2'b00;
      k_per = 16'h0001;
      k_frq = 16'hFFFF;
      clr_per = 1'b0;
      clr_frq = 1'b0;
      failures = 0;
      compares = 0;
      repeat (16) @(negedge sys_clk_i);
      rst_b_i = 1'b1;
      test_scales;
      test_freq_gate;
      test_period_read;
      test_done;
   end
   // scales need about 85000 cycles, the rest about 20000
   initial
   begin
      repeat (120000) @(posedge sys_clk_i);
      failures++;
      $display("mismatch at %0t: timeout", $time);
      test_done;
   end
endmodule : testbench
